// ---- pkg/hlpt_pkg.sv ----
/*
 hlpt_pkg: register map, reset values, mode codes and carrier types of the
 hardware-limit period timer.
 Assumes: one AXI4-Lite slave with 32-bit data, 8-bit register fields in the low byte.
*/
package hlpt_pkg;

   // register byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_MODE = 8'h04;
   localparam logic [7:0] REG_PERIOD = 8'h08;
   localparam logic [7:0] REG_COUNT = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_IRQ_EN = 8'h14;

   // field positions
   localparam int CTRL_RUN_BIT = 7;
   localparam int STATUS_FLAG_BIT = 0;
   localparam int IRQ_EN_BIT = 0;

   // values after reset
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [4:0] MODE_RST = 5'h00;
   localparam logic [7:0] PERIOD_RST = 8'hFF;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [3:0] POST_RST = 4'h0;
   localparam logic [6:0] PRE_RST = 7'h00;

   // cycle counts
   localparam int SYNC_TICKS = 2;
   localparam int IRQ_LATENCY = 2;

   // mode codes
   localparam logic [4:0] M_SW_GATE = 5'h00;
   localparam logic [4:0] M_HW_GATE_HI = 5'h01;
   localparam logic [4:0] M_HW_GATE_LO = 5'h02;
   localparam logic [4:0] M_ER_ANY = 5'h03;
   localparam logic [4:0] M_ER_RISE = 5'h04;
   localparam logic [4:0] M_ER_FALL = 5'h05;
   localparam logic [4:0] M_LR_LOW = 5'h06;
   localparam logic [4:0] M_LR_HIGH = 5'h07;
   localparam logic [4:0] M_OS_SW = 5'h08;
   localparam logic [4:0] M_OS_RISE = 5'h09;
   localparam logic [4:0] M_OS_FALL = 5'h0A;
   localparam logic [4:0] M_OS_ANY = 5'h0B;
   localparam logic [4:0] M_OSL_RISE = 5'h0C;
   localparam logic [4:0] M_OSL_FALL = 5'h0D;
   localparam logic [4:0] M_OSL_RISE_LR = 5'h0E;
   localparam logic [4:0] M_OSL_FALL_HR = 5'h0F;
   localparam logic [4:0] M_MONO_RISE = 5'h11;
   localparam logic [4:0] M_MONO_FALL = 5'h12;
   localparam logic [4:0] M_MONO_ANY = 5'h13;
   localparam logic [4:0] M_OS_LVL_LOW = 5'h16;
   localparam logic [4:0] M_OS_LVL_HIGH = 5'h17;

   // edge kinds
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_ANY = 2'h3;

   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // software control register
   typedef struct packed {
      logic run;
      logic [2:0] prescale_select;
      logic [3:0] postscale_select;
   } hlpt_ctrl_t;

   // counter sequencing
   typedef enum logic [1:0] {ST_WAIT, ST_COUNT, ST_HOLD_A, ST_HOLD_B} hlpt_state_t;

endpackage

// ---- rtl/hlpt_timer.sv ----
/*
 hlpt_timer: 8-bit period timer with prescaler, postscaler, period-match interrupt
 and a five-bit hardware-limit mode driven by an external reset/trigger signal.
 Assumes: AXI4-Lite master on aclk; timer_clock and ext_reset_trigger are pins from
 outside and are synchronised here; the timer clock is slower than aclk / 2.
*/
// Operation
// - a five-bit mode field selects the timer's behaviour.
// - count and period are 8-bit; count is compared against period.
// - modes 10110/10111 hold in reset at reset level, start on run plus level.
// - edge-started modes need a fresh edge after run is set again.
// - one-shot match clears run next clock and stops count at zero.
// - monostable match stops count at zero, run stays set.
// - flag rises when postscaler reaches selected ratio, 1:1 to 1:16.
// - interrupt reaches processor only when enable bit is set.
// - flag follows postscaled event within two cycles.
// - software gate counts each clock while run, holds otherwise.
// - free-running match resets count next clock, continues from zero.
// - mode 00001 counts while trigger high, 00010 while low, both need run.
// - edge reset modes: 00011 either edge, 00100 rising, 00101 falling.
// - after an early edge reset counting resumes two clocks later.
// - level reset: 00110 resets on low level, 00111 on high.
// - level reset modes ignore the trigger while run is clear.
// - level reset two clocks after level, resume two clocks after release.
// - mode 01000 runs on run set, match resets count and clears run.
// - edge start one-shot: 01001 rising, 01010 falling, 01011 either edge.
// - 01100/01101 start on first edge, later edges reset the count.
// - hardware-limit one-shot resumes two clocks after each reset edge.
// - hardware-limit one-shot ignores edges until run is set.
// - run and trigger pass two prescaled timer clocks of synchronisation.
`timescale 1ns/100ps
`default_nettype none

module hlpt_timer
   import hlpt_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address channel
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address channel
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins from outside
   input wire logic timer_clock,
   input wire logic ext_reset_trigger,
   // to downstream consumers
   output logic [7:0] count_value,
   output logic postscaled_pulse,
   output logic period_irq
);

   // selects one edge kind out of rise and fall
   function automatic logic edge_hit(input logic [1:0] kind, input logic rise,
                                     input logic fall);
      edge_hit = ((kind == EDGE_RISE) && rise) || ((kind == EDGE_FALL) && fall) ||
                 ((kind == EDGE_ANY) && (rise || fall));
   endfunction

   // terminal count of the prescaler for a 1:2^sel ratio
   function automatic logic [6:0] pre_limit(input logic [2:0] sel);
      logic [7:0] full;
      full = 8'(8'h01 << sel);
      pre_limit = 7'(full - 8'h01);
   endfunction

   hlpt_ctrl_t ctrl;
   logic [4:0] mode;
   logic [7:0] period_value;
   logic [7:0] period_buf;
   logic period_irq_flag;
   logic period_irq_enable;
   logic tclk_meta, tclk_sync, tclk_prev;
   logic ers_meta, ers_sync;
   logic [6:0] pre_cnt;
   logic [3:0] post_cnt;
   logic [SYNC_TICKS-1:0] run_pipe;
   logic [SYNC_TICKS:0] ers_pipe;
   hlpt_state_t state;
   logic spent;
   logic irq_stage;
   logic tick, pre_tick;
   logic run_d, ers_d, rise, fall;
   logic wr_hit, rd_hit;
   logic wr_ctrl, wr_mode, wr_period, wr_count, wr_status, wr_irq_en;
   logic rd_ok;
   logic [7:0] rd_byte;
   // mode decode
   logic sw_start, lvl_start, lvl_rst, gate_on, gate_level, rst_level;
   logic one_shot, mono;
   logic [1:0] start_kind, rst_kind;
   // derived events
   logic lvl_rst_now, edge_rst_now, gate_ok, counting, match_evt, ext_rst_evt;
   logic clr_scalers, run_clr;

   // pins pass two flip-flops before any logic reads them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tclk_meta <= 1'b0;
         tclk_sync <= 1'b0;
         tclk_prev <= 1'b0;
         ers_meta <= 1'b0;
         ers_sync <= 1'b0;
      end else begin
         tclk_meta <= timer_clock;
         tclk_sync <= tclk_meta;
         tclk_prev <= tclk_sync;
         ers_meta <= ext_reset_trigger;
         ers_sync <= ers_meta;
      end
   end

   // timer clock edge and prescaled tick
   assign tick = tclk_sync && !tclk_prev;
   assign pre_tick = tick && (pre_cnt == pre_limit(ctrl.prescale_select));

   // prescaler counter
   always_ff @(posedge aclk) begin
      if (!aresetn || clr_scalers) begin
         pre_cnt <= PRE_RST;
      end else if (pre_tick) begin
         pre_cnt <= PRE_RST;
      end else if (tick) begin
         pre_cnt <= pre_cnt + 7'h01;
      end
   end

   // run bit and trigger delayed by two prescaled timer clocks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_pipe <= '0;
         ers_pipe <= '0;
      end else if (pre_tick) begin
         run_pipe <= {run_pipe[SYNC_TICKS-2:0], ctrl.run};
         ers_pipe <= {ers_pipe[SYNC_TICKS-1:0], ers_sync};
      end
   end

   assign run_d = run_pipe[SYNC_TICKS-1];
   assign ers_d = ers_pipe[SYNC_TICKS-1];
   assign rise = ers_d && !ers_pipe[SYNC_TICKS];
   assign fall = !ers_d && ers_pipe[SYNC_TICKS];

   // mode field decode
   always_comb begin
      sw_start = 1'b0;
      lvl_start = 1'b0;
      lvl_rst = 1'b0;
      rst_level = 1'b0;
      gate_on = 1'b0;
      gate_level = 1'b0;
      one_shot = 1'b0;
      mono = 1'b0;
      start_kind = EDGE_NONE;
      rst_kind = EDGE_NONE;
      unique case (mode)
         M_SW_GATE: sw_start = 1'b1;
         M_HW_GATE_HI: begin
            sw_start = 1'b1;
            gate_on = 1'b1;
            gate_level = 1'b1;
         end
         M_HW_GATE_LO: begin
            sw_start = 1'b1;
            gate_on = 1'b1;
         end
         M_ER_ANY: begin
            sw_start = 1'b1;
            rst_kind = EDGE_ANY;
         end
         M_ER_RISE: begin
            sw_start = 1'b1;
            rst_kind = EDGE_RISE;
         end
         M_ER_FALL: begin
            sw_start = 1'b1;
            rst_kind = EDGE_FALL;
         end
         M_LR_LOW: begin
            sw_start = 1'b1;
            lvl_rst = 1'b1;
         end
         M_LR_HIGH: begin
            sw_start = 1'b1;
            lvl_rst = 1'b1;
            rst_level = 1'b1;
         end
         M_OS_SW: begin
            sw_start = 1'b1;
            one_shot = 1'b1;
         end
         M_OS_RISE: begin
            start_kind = EDGE_RISE;
            one_shot = 1'b1;
         end
         M_OS_FALL: begin
            start_kind = EDGE_FALL;
            one_shot = 1'b1;
         end
         M_OS_ANY: begin
            start_kind = EDGE_ANY;
            one_shot = 1'b1;
         end
         M_OSL_RISE: begin
            start_kind = EDGE_RISE;
            rst_kind = EDGE_RISE;
            one_shot = 1'b1;
         end
         M_OSL_FALL: begin
            start_kind = EDGE_FALL;
            rst_kind = EDGE_FALL;
            one_shot = 1'b1;
         end
         M_OSL_RISE_LR: begin
            start_kind = EDGE_RISE;
            lvl_rst = 1'b1;
            one_shot = 1'b1;
         end
         M_OSL_FALL_HR: begin
            start_kind = EDGE_FALL;
            lvl_rst = 1'b1;
            rst_level = 1'b1;
            one_shot = 1'b1;
         end
         M_MONO_RISE: begin
            start_kind = EDGE_RISE;
            mono = 1'b1;
         end
         M_MONO_FALL: begin
            start_kind = EDGE_FALL;
            mono = 1'b1;
         end
         M_MONO_ANY: begin
            start_kind = EDGE_ANY;
            mono = 1'b1;
         end
         M_OS_LVL_LOW: begin
            lvl_start = 1'b1;
            lvl_rst = 1'b1;
            one_shot = 1'b1;
         end
         M_OS_LVL_HIGH: begin
            lvl_start = 1'b1;
            lvl_rst = 1'b1;
            rst_level = 1'b1;
            one_shot = 1'b1;
         end
         default: ; // reserved codes never start the counter
      endcase
   end

   // trigger is only looked at while the delayed run bit is set
   assign lvl_rst_now = run_d && lvl_rst && (ers_d == rst_level);
   assign edge_rst_now = run_d && (state == ST_COUNT) && edge_hit(rst_kind, rise, fall);
   assign gate_ok = !gate_on || (ers_d == gate_level);
   assign counting = run_d && (state == ST_COUNT) && gate_ok && !lvl_rst_now;
   assign match_evt = pre_tick && counting && !edge_rst_now &&
                      (count_value == period_buf);
   assign ext_rst_evt = pre_tick && (lvl_rst_now || edge_rst_now);
   assign clr_scalers = wr_count || wr_ctrl || ext_rst_evt;
   assign run_clr = match_evt && one_shot;

   // start, stop and resume sequencing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_WAIT;
      end else if (pre_tick) begin
         if (!run_d) begin
            state <= ST_WAIT;
         end else begin
            unique case (state)
               ST_WAIT: begin
                  if (!spent && !lvl_rst_now &&
                      (sw_start || lvl_start || edge_hit(start_kind, rise, fall))) begin
                     state <= ST_COUNT;
                  end
               end
               ST_COUNT: begin
                  if (edge_rst_now) begin
                     state <= ST_HOLD_A;
                  end else if (match_evt && (one_shot || mono)) begin
                     state <= ST_WAIT;
                  end
               end
               ST_HOLD_A: state <= ST_HOLD_B;
               ST_HOLD_B: state <= ST_COUNT;
            endcase
         end
      end
   end

   // a finished one-shot waits for run to be seen low before restarting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         spent <= 1'b0;
      end else if (pre_tick && !run_d) begin
         spent <= 1'b0;
      end else if (run_clr) begin
         spent <= 1'b1;
      end
   end

   // count register: software write, resets, then increment
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_value <= COUNT_RST;
      end else if (wr_count) begin
         count_value <= s_axi_wdata[7:0];
      end else if (ext_rst_evt) begin
         count_value <= COUNT_RST;
      end else if (match_evt) begin
         count_value <= COUNT_RST;
      end else if (pre_tick && counting) begin
         count_value <= count_value + 8'h01;
      end
   end

   // double-buffered period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_buf <= PERIOD_RST;
      end else if (wr_count || wr_ctrl || wr_mode || match_evt || ext_rst_evt) begin
         period_buf <= period_value;
      end
   end

   // postscaler and its one-cycle output pulse
   always_ff @(posedge aclk) begin
      if (!aresetn || clr_scalers) begin
         post_cnt <= POST_RST;
         postscaled_pulse <= 1'b0;
      end else if (match_evt && (post_cnt == ctrl.postscale_select)) begin
         post_cnt <= POST_RST;
         postscaled_pulse <= 1'b1;
      end else begin
         post_cnt <= match_evt ? post_cnt + 4'h1 : post_cnt;
         postscaled_pulse <= 1'b0;
      end
   end

   // flag set two cycles after the postscaled pulse; set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stage <= 1'b0;
         period_irq_flag <= 1'b0;
      end else begin
         irq_stage <= postscaled_pulse;
         if (irq_stage) begin
            period_irq_flag <= 1'b1;
         end else if (wr_status && s_axi_wdata[STATUS_FLAG_BIT]) begin
            period_irq_flag <= 1'b0;
         end
      end
   end

   // interrupt line gated by the enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_irq <= 1'b0;
      end else begin
         period_irq <= period_irq_flag && period_irq_enable;
      end
   end

   // control register; a software set of run wins over the hardware clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= hlpt_ctrl_t'(CTRL_RST);
      end else if (wr_ctrl) begin
         ctrl <= hlpt_ctrl_t'(s_axi_wdata[7:0]);
      end else if (run_clr) begin
         ctrl.run <= 1'b0;
      end
   end

   // mode, period and enable registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode <= MODE_RST;
         period_value <= PERIOD_RST;
         period_irq_enable <= 1'b0;
      end else begin
         if (wr_mode) begin
            mode <= s_axi_wdata[4:0];
         end
         if (wr_period) begin
            period_value <= s_axi_wdata[7:0];
         end
         if (wr_irq_en) begin
            period_irq_enable <= s_axi_wdata[IRQ_EN_BIT];
         end
      end
   end

   // write decode; a write without the low byte lane stores nothing
   assign wr_hit = s_axi_awready && s_axi_awvalid && s_axi_wvalid && s_axi_wstrb[0];
   assign wr_ctrl = wr_hit && (s_axi_awaddr == REG_CTRL);
   assign wr_mode = wr_hit && (s_axi_awaddr == REG_MODE);
   assign wr_period = wr_hit && (s_axi_awaddr == REG_PERIOD);
   assign wr_count = wr_hit && (s_axi_awaddr == REG_COUNT);
   assign wr_status = wr_hit && (s_axi_awaddr == REG_STATUS);
   assign wr_irq_en = wr_hit && (s_axi_awaddr == REG_IRQ_EN);

   // write channels: both taken together, then one response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (s_axi_awready) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (s_axi_awaddr[7:2] <= REG_IRQ_EN[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid) begin
         s_axi_bvalid <= !s_axi_bready;
      end else if (s_axi_awvalid && s_axi_wvalid) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end
   end

   // read decode
   assign rd_hit = s_axi_arready && s_axi_arvalid;
   always_comb begin
      rd_ok = 1'b1;
      rd_byte = 8'h00;
      unique case (s_axi_araddr)
         REG_CTRL: rd_byte = ctrl;
         REG_MODE: rd_byte = {3'h0, mode};
         REG_PERIOD: rd_byte = period_value;
         REG_COUNT: rd_byte = count_value;
         REG_STATUS: rd_byte = {7'h00, period_irq_flag};
         REG_IRQ_EN: rd_byte = {7'h00, period_irq_enable};
         default: rd_ok = 1'b0;
      endcase
   end

   // read channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_hit) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         s_axi_rvalid <= !s_axi_rready;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready;
      end
   end

endmodule

`default_nettype wire

// ---- tb/hlpt_chk.sv ----
/*
 hlpt_chk: bus and counter assertions on the timer's ports.
 Assumes: bound to hlpt_timer, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module hlpt_chk
   import hlpt_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // timer outputs
   input wire logic [7:0] count_value,
   input wire logic postscaled_pulse,
   input wire logic period_irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // write and read channels
   chk_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
      else $error("awready and wready differ");
   chk_aw_take: assert property (s_axi_awready |-> $past(s_axi_awvalid && s_axi_wvalid)
      ##1 (!s_axi_awready && s_axi_bvalid)) else $error("write not answered");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");
   chk_ar_take: assert property (s_axi_arready |-> $past(s_axi_arvalid)
      ##1 (!s_axi_arready && s_axi_rvalid)) else $error("read not answered");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped");
   // counter moves up by one or back to zero unless software loaded it
   chk_count_step: assert property ($changed(count_value) && !$past(s_axi_awready) |->
      count_value == $past(count_value) + 8'h01 || count_value == 8'h00)
      else $error("count jumped");
   chk_pulse_one: assert property (postscaled_pulse |=> !postscaled_pulse)
      else $error("postscaled pulse too wide");
   chk_irq_cause: assert property ($rose(period_irq) && !$past(s_axi_awready, 2) |->
      $past(postscaled_pulse, 2) || $past(postscaled_pulse, 3) || $past(postscaled_pulse, 4))
      else $error("interrupt without event");
endmodule

`default_nettype wire

// ---- tb/hlpt_trig_model.sv ----
/*
 hlpt_trig_model: source of the timer clock and the external reset/trigger.
 Assumes: timer clock runs free at aclk / 8.
*/
`timescale 1ns/100ps
`default_nettype none

module hlpt_trig_model (
   // clock and requested level
   input wire logic aclk,
   input wire logic req_level,
   // timer pins
   output logic timer_clock,
   output logic ext_reset_trigger = 1'b0
);
   logic [2:0] div = 3'h0;
   logic [3:0] since = 4'h6;

   // timer clock, four aclk high and four low
   always_ff @(posedge aclk) begin
      div <= div + 3'h1;
   end
   assign timer_clock = div[2];

   // trigger follows the request, changes kept six ticks apart
   always_ff @(posedge aclk) begin
      if (ext_reset_trigger != req_level && since >= 4'h6) begin
         ext_reset_trigger <= req_level;
         since <= 4'h0;
      end else if (div == 3'h3 && since < 4'h6) begin
         since <= since + 4'h1;
      end
   end
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
/*
 testbench: register-level tests of the period timer over AXI4-Lite.
 Assumes: hlpt_trig_model drives the timer clock and trigger pins.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end

module testbench
   import hlpt_pkg::*;
;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, req_level;
   logic awready, wready, bvalid, arready, rvalid, tclk, trig, pulse, irq;
   logic [7:0] awaddr, araddr, count;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   int miscompares = 0;
   int n_tests = 0;
   int n;

   // clock source
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   hlpt_timer DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .timer_clock(tclk), .ext_reset_trigger(trig), .count_value(count),
      .postscaled_pulse(pulse), .period_irq(irq));

   hlpt_trig_model u_src (.aclk(aclk), .req_level(req_level), .timer_clock(tclk),
      .ext_reset_trigger(trig));

   // one write, answer compared
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] e = RESP_OKAY);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK(bresp, e)
      @(posedge aclk);
   endtask

   // one read, data and answer compared
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er = RESP_OKAY);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      `CHK(rdata, e)
      `CHK(rresp, er)
      @(posedge aclk);
   endtask

   // bounded waits on the timer outputs
   task automatic wait_cnt(input logic [7:0] v);
      for (int i = 0; i < 400 && count !== v; i++) @(posedge aclk);
      `CHK(count, v)
   endtask
   task automatic wait_pulse();
      for (int i = 0; i < 9000 && pulse !== 1'b1; i++) @(posedge aclk);
   endtask

   // spacing of postscaled pulses, eight aclk per tick, period 3
   task automatic gap(input logic [7:0] ctl);
      int k;
      wr(REG_CTRL, {24'h0, ctl});
      wait_pulse();
      @(posedge aclk);
      for (k = 1; k < 9000 && pulse !== 1'b1; k++) @(posedge aclk);
      `CHK(k, 32 * (1 << ctl[6:4]) * (ctl[3:0] + 1))
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (60000) @(posedge aclk);
      miscompares++;
      give_verdict();
   end

   // test sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, req_level} = 7'h00;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 6; i++) rd(8'(4 * i), (i == 2) ? 32'hFF : 32'h0);
      rd(8'h18, 32'h0, RESP_SLVERR);
      wr(8'h18, 32'h1, RESP_SLVERR);
      // software gate, free running
      wr(REG_IRQ_EN, 32'h1);
      wr(REG_PERIOD, 32'h3);
      wr(REG_CTRL, 32'h80);
      wait_cnt(8'h03);
      while (count === 8'h03) @(posedge aclk);
      `CHK(count, 8'h00)
      wait_pulse();
      repeat (4) @(posedge aclk);
      `CHK(irq, 1'b1)
      rd(REG_STATUS, 32'h1);
      wr(REG_CTRL, 32'h0);
      repeat (40) @(posedge aclk);
      n = count;
      repeat (100) @(posedge aclk);
      `CHK(count, n[7:0])
      wr(REG_STATUS, 32'h1);
      rd(REG_STATUS, 32'h0);
      wr(REG_IRQ_EN, 32'h0);
      wr(REG_CTRL, 32'h80);
      wait_pulse();
      repeat (4) @(posedge aclk);
      `CHK(irq, 1'b0)
      for (int i = 0; i < 3; i++) gap(i == 0 ? 8'h80 : (i == 1 ? 8'h93 : 8'h8F));
      wr(REG_CTRL, 32'h0);
      // software start one-shot
      wr(REG_MODE, {27'h0, M_OS_SW});
      wr(REG_PERIOD, 32'h2);
      wr(REG_COUNT, 32'h0);
      wr(REG_CTRL, 32'h80);
      wait_cnt(8'h02);
      repeat (200) @(posedge aclk);
      rd(REG_CTRL, 32'h0);
      `CHK(count, 8'h00)
      // rising edge monostable
      wr(REG_MODE, {27'h0, M_MONO_RISE});
      wr(REG_CTRL, 32'h80);
      repeat (100) @(posedge aclk);
      `CHK(count, 8'h00)
      req_level <= 1'b1;
      wait_cnt(8'h02);
      repeat (200) @(posedge aclk);
      rd(REG_CTRL, 32'h80);
      `CHK(count, 8'h00)
      // high level reset
      wr(REG_CTRL, 32'h0);
      wr(REG_MODE, {27'h0, M_LR_HIGH});
      wr(REG_PERIOD, 32'hFF);
      wr(REG_CTRL, 32'h80);
      repeat (200) @(posedge aclk);
      `CHK(count, 8'h00)
      req_level <= 1'b0;
      wait_cnt(8'h05);
      // hardware gate, counts while trigger high
      wr(REG_CTRL, 32'h0);
      wr(REG_MODE, {27'h0, M_HW_GATE_HI});
      wr(REG_COUNT, 32'h0);
      wr(REG_CTRL, 32'h80);
      repeat (200) @(posedge aclk);
      `CHK(count, 8'h00)
      req_level <= 1'b1;
      wait_cnt(8'h04);
      // rising edge reset
      wr(REG_CTRL, 32'h0);
      wr(REG_MODE, {27'h0, M_ER_RISE});
      req_level <= 1'b0;
      repeat (100) @(posedge aclk);
      wr(REG_CTRL, 32'h80);
      wait_cnt(8'h14);
      req_level <= 1'b1;
      wait_cnt(8'h00);
      give_verdict();
   end
endmodule

bind hlpt_timer hlpt_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .count_value(count_value), .postscaled_pulse(postscaled_pulse), .period_irq(period_irq));

`default_nettype wire
